// ### tw_consts.svh
// Purpose: offsets, bit positions, reset values, status codes and timing of the
//          two-wire master transmitter
// Assumes: 200 MHz core clock
// Notes: status codes are full bytes with the prescaler bits at zero
`ifndef TW_CONSTS_SVH
`define TW_CONSTS_SVH

// register offsets
`define TW_A_CTL 2'h0
`define TW_A_STAT 2'h1
`define TW_A_DATA 2'h2
`define TW_A_OWN 2'h3

// control register bit positions
`define TW_B_FLAG 7
`define TW_B_ACK 6
`define TW_B_STA 5
`define TW_B_STO 4
`define TW_B_WCOL 3
`define TW_B_EN 2

// reset values
`define TW_RST_CODE 8'hf8
`define TW_RST_OWN 8'h00
`define TW_RST_PRESC 2'h0

// status codes
`define TW_SC_START 8'h08
`define TW_SC_RSTART 8'h10
`define TW_SC_AW_ACK 8'h18
`define TW_SC_AW_NACK 8'h20
`define TW_SC_D_ACK 8'h28
`define TW_SC_D_NACK 8'h30
`define TW_SC_ARB 8'h38
`define TW_SC_AR_ACK 8'h40
`define TW_SC_AR_NACK 8'h48
`define TW_SC_SLV_W 8'h68
`define TW_SC_SLV_GC 8'h78
`define TW_SC_SLV_R 8'hb0

// bits per byte before the acknowledge slot
`define TW_NBITS 4'd8

// timing: quarter of a bus bit, least time, rounded up
`define TW_CLK_MHZ 200
`define TW_QTR_NS 2500
`define TW_QTR_CYC ((`TW_QTR_NS * `TW_CLK_MHZ + 999) / 1000)

`endif

// ### tw_pkg.sv
// Purpose: types of the two-wire master transmitter
// Assumes: constants come from tw_consts.svh
// Notes: state codes are Gray along idle, wait, start, hold, send
package tw_pkg;

  typedef enum logic [2:0] {
    TW_IDLE = 3'b000,
    TW_WAIT = 3'b001,
    TW_START = 3'b011,
    TW_HOLD = 3'b010,
    TW_SEND = 3'b110,
    TW_STOP = 3'b111,
    TW_SLV = 3'b101
  } tw_state_t;

endpackage

// ### tw_sync.sv
// Purpose: two-flop synchroniser for one bus pin
// Assumes: pin idles high
// Notes: first flop feeds only the second
`timescale 1ns/1ps
`default_nettype none
module tw_sync (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // pin and synchronised level
  input wire logic d,
  output logic q
);

  logic meta;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta <= 1'b1;
      q <= 1'b1;
    end else begin
      meta <= d;
      q <= meta;
    end
  end

endmodule
`default_nettype wire

// ### tw_tick.sv
// Purpose: quarter-bit tick for the bus engine
// Assumes: run low pauses the count, clr restarts it
// Notes: tick is a one-cycle pulse
`timescale 1ns/1ps
`default_nettype none
`include "tw_consts.svh"
module tw_tick (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic run,
  input wire logic clr,
  // output
  output logic tick
);

  logic [9:0] cnt;

  always_ff @(posedge clk) begin
    if (rst || clr) begin
      cnt <= 10'h000;
      tick <= 1'b0;
    end else if (run && cnt == 10'(`TW_QTR_CYC - 1)) begin
      cnt <= 10'h000;
      tick <= 1'b1;
    end else if (run) begin
      cnt <= cnt + 10'h001;
      tick <= 1'b0;
    end else begin
      tick <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// ### tw_master_tx.sv
// Purpose: two-wire master transmitter with status codes and software pacing
// Assumes: open-drain pins, oe high pulls the wire low
// Notes: master receive and slave data phases join through the status code
//
// Operation
// - after repeated START, address any slave without a STOP
// - repeated START keeps the bus while changing slave or direction
// - START gives 0x08; software loads address, device sends it, samples ack
// - in 0x10 a read address is sent and hands off to master receive
// - address with write bit reports 0x18 on ack, 0x20 on nack
// - data byte acked reports 0x28
// - data byte not acked reports 0x30
// - in 0x18..0x30 a plain clear sends the loaded data byte
// - clear with start only sends a repeated START
// - clear with stop only sends STOP and drops the stop request
// - clear with both sends STOP then START, drops the stop request
// - arbitration lost in address or data reports 0x38
// - in 0x38 a clear without start releases the bus, unaddressed slave
// - in 0x38 a clear with start waits for a free bus, then START
// - lost and addressed as slave reports 0x68, 0x78 or 0xb0
// - status codes read with prescaler bits at zero
// - transfer stays suspended while the flag is set
// - data write with flag low is dropped, write collision set
//
// Chosen here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "tw_consts.svh"
module tw_master_tx
  import tw_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // clock wire
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  // data wire
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe
);

  tw_state_t st;
  logic scl_s, sda_s, scl_d, sda_d;
  logic flag, ack_enable, start_request, stop_request;
  logic write_collision_flag, enable, busy, low_level;
  logic [7:0] code, shift_data_reg, own_addr, slv_code;
  logic [1:0] presc, ph;
  logic [3:0] bitn;
  logic is_addr, rd_mode, rep, smp;
  logic hw_set, hw_stop_clr, tick, timed;
  logic [7:0] hw_code;
  logic ctl_wr, data_wr, scl_rise, scl_fall;
  logic own_hit, gc_hit;

  tw_sync u_sync_scl (
    .clk(clk),
    .rst(rst),
    .d(scl_in),
    .q(scl_s)
  );

  tw_sync u_sync_sda (
    .clk(clk),
    .rst(rst),
    .d(sda_in),
    .q(sda_s)
  );

  // stretch: the high quarter only counts once the wire is really high
  assign timed = (st == TW_START) || (st == TW_SEND) || (st == TW_STOP);

  tw_tick u_tick (
    .clk(clk),
    .rst(rst),
    .run(timed && (ph != 2'd2 || scl_s)),
    .clr(!timed),
    .tick(tick)
  );

  assign ctl_wr = reg_wr && reg_addr == `TW_A_CTL;
  assign data_wr = reg_wr && reg_addr == `TW_A_DATA;
  assign scl_rise = scl_s && !scl_d;
  assign scl_fall = !scl_s && scl_d;
  assign own_hit = shift_data_reg[7:1] == own_addr[7:1];
  assign gc_hit = shift_data_reg[7:1] == 7'h00 && own_addr[0] && !shift_data_reg[0];
  assign scl_out = low_level;
  assign sda_out = low_level;

  // delayed pin levels for edge and condition detection
  always_ff @(posedge clk) begin
    if (rst) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      low_level <= 1'b0;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
      low_level <= 1'b0;
    end
  end

  // bus busy between a START and a STOP seen on the wires
  always_ff @(posedge clk) begin
    if (rst) begin
      busy <= 1'b0;
    end else if (scl_s && scl_d && sda_d && !sda_s) begin
      busy <= 1'b1;
    end else if (scl_s && scl_d && !sda_d && sda_s) begin
      busy <= 1'b0;
    end
  end

  // set wins over a clear in the same cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      flag <= 1'b0;
    end else if (hw_set) begin
      flag <= 1'b1;
    end else if (ctl_wr && reg_wdata[`TW_B_FLAG]) begin
      flag <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ack_enable <= 1'b0;
      start_request <= 1'b0;
      enable <= 1'b0;
    end else if (ctl_wr) begin
      ack_enable <= reg_wdata[`TW_B_ACK];
      start_request <= reg_wdata[`TW_B_STA];
      enable <= reg_wdata[`TW_B_EN];
    end
  end

  // hardware drops the stop request after the STOP
  always_ff @(posedge clk) begin
    if (rst) begin
      stop_request <= 1'b0;
    end else if (ctl_wr) begin
      stop_request <= reg_wdata[`TW_B_STO];
    end else if (hw_stop_clr) begin
      stop_request <= 1'b0;
    end
  end

  // data write with flag low collides
  always_ff @(posedge clk) begin
    if (rst) begin
      write_collision_flag <= 1'b0;
    end else if (data_wr) begin
      write_collision_flag <= !flag;
    end
  end

  // code latched with the flag, low bits kept zero
  always_ff @(posedge clk) begin
    if (rst) begin
      code <= `TW_RST_CODE;
    end else if (hw_set) begin
      code <= hw_code;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      presc <= `TW_RST_PRESC;
      own_addr <= `TW_RST_OWN;
    end else if (reg_wr && reg_addr == `TW_A_STAT) begin
      presc <= reg_wdata[1:0];
    end else if (reg_wr && reg_addr == `TW_A_OWN) begin
      own_addr <= reg_wdata;
    end
  end

  // code above the prescaler bits, bit 2 reads zero
  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (!reg_rd) begin
      reg_rdata <= 8'h00;
    end else begin
      case (reg_addr)
        `TW_A_CTL: reg_rdata <= {flag, ack_enable, start_request, stop_request,
                                 write_collision_flag, enable, 2'b00};
        `TW_A_STAT: reg_rdata <= {code[7:3], 1'b0, presc};
        `TW_A_DATA: reg_rdata <= shift_data_reg;
        default: reg_rdata <= own_addr;
      endcase
    end
  end

  // bus engine
  always_ff @(posedge clk) begin
    if (rst) begin
      st <= TW_IDLE;
      ph <= 2'd0;
      bitn <= 4'd0;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
      shift_data_reg <= 8'h00;
      is_addr <= 1'b0;
      rd_mode <= 1'b0;
      rep <= 1'b0;
      smp <= 1'b1;
      slv_code <= `TW_SC_SLV_W;
      hw_set <= 1'b0;
      hw_code <= `TW_RST_CODE;
      hw_stop_clr <= 1'b0;
    end else if (!enable) begin
      st <= TW_IDLE;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
      hw_set <= 1'b0;
      hw_stop_clr <= 1'b0;
      if (data_wr && flag) begin
        shift_data_reg <= reg_wdata;
      end
    end else begin
      hw_set <= 1'b0;
      hw_stop_clr <= 1'b0;
      if (data_wr && flag) begin
        shift_data_reg <= reg_wdata;
      end
      case (st)
        TW_IDLE: begin
          if (start_request && !flag) begin
            st <= TW_WAIT;
          end
        end
        // START only once the bus is free
        TW_WAIT: begin
          if (!busy) begin
            st <= TW_START;
            rep <= 1'b0;
            ph <= 2'd0;
          end
        end
        TW_START: begin
          if (tick) begin
            ph <= ph + 2'd1;
            case (ph)
              2'd0: sda_oe <= 1'b0;
              2'd1: scl_oe <= 1'b0;
              2'd2: sda_oe <= 1'b1;
              default: begin
                scl_oe <= 1'b1;
                hw_set <= 1'b1;
                hw_code <= rep ? `TW_SC_RSTART : `TW_SC_START;
                st <= TW_HOLD;
              end
            endcase
          end
        end
        TW_SEND: begin
          if (tick) begin
            ph <= ph + 2'd1;
            case (ph)
              2'd0: sda_oe <= (bitn == `TW_NBITS) ? 1'b0 : !shift_data_reg[7];
              2'd1: scl_oe <= 1'b0;
              2'd2: begin
                smp <= sda_s;
                // released bit seen low, arbitration lost
                if (bitn != `TW_NBITS && shift_data_reg[7] && !sda_s) begin
                  scl_oe <= 1'b0;
                  sda_oe <= 1'b0;
                  shift_data_reg <= {shift_data_reg[6:0], 1'b0};
                  bitn <= bitn + 4'd1;
                  ph <= 2'd0;
                  if (is_addr) begin
                    st <= TW_SLV;
                  end else begin
                    hw_set <= 1'b1;
                    hw_code <= `TW_SC_ARB;
                    st <= TW_HOLD;
                  end
                end
              end
              default: begin
                scl_oe <= 1'b1;
                if (bitn == `TW_NBITS) begin
                  hw_set <= 1'b1;
                  st <= TW_HOLD;
                  if (is_addr && rd_mode) begin
                    hw_code <= smp ? `TW_SC_AR_NACK : `TW_SC_AR_ACK;
                  end else if (is_addr) begin
                    hw_code <= smp ? `TW_SC_AW_NACK : `TW_SC_AW_ACK;
                  end else if (smp) begin
                    hw_code <= `TW_SC_D_NACK;
                  end else begin
                    hw_code <= `TW_SC_D_ACK;
                  end
                end else begin
                  shift_data_reg <= {shift_data_reg[6:0], smp};
                  bitn <= bitn + 4'd1;
                end
              end
            endcase
          end
        end
        TW_STOP: begin
          if (tick) begin
            ph <= ph + 2'd1;
            case (ph)
              2'd0: sda_oe <= 1'b1;
              2'd1: scl_oe <= 1'b0;
              2'd2: sda_oe <= 1'b0;
              default: begin
                // START follows the STOP when asked
                hw_stop_clr <= 1'b1;
                st <= start_request ? TW_WAIT : TW_IDLE;
              end
            endcase
          end
        end
        // finish the address as a slave and compare
        TW_SLV: begin
          case (ph)
            2'd0: begin
              if (bitn == `TW_NBITS) begin
                if (ack_enable && (own_hit || gc_hit)) begin
                  ph <= 2'd1;
                  if (gc_hit && !own_hit) begin
                    slv_code <= `TW_SC_SLV_GC;
                  end else begin
                    slv_code <= shift_data_reg[0] ? `TW_SC_SLV_R : `TW_SC_SLV_W;
                  end
                end else begin
                  hw_set <= 1'b1;
                  hw_code <= `TW_SC_ARB;
                  st <= TW_HOLD;
                end
              end else if (scl_rise) begin
                shift_data_reg <= {shift_data_reg[6:0], sda_s};
                bitn <= bitn + 4'd1;
              end
            end
            2'd1: begin
              if (scl_fall) begin
                sda_oe <= 1'b1;
                ph <= 2'd2;
              end
            end
            2'd2: begin
              if (scl_rise) begin
                ph <= 2'd3;
              end
            end
            default: begin
              if (scl_fall) begin
                sda_oe <= 1'b0;
                scl_oe <= 1'b1;
                hw_set <= 1'b1;
                hw_code <= slv_code;
                st <= TW_HOLD;
              end
            end
          endcase
        end
        // nothing moves until the flag is cleared
        TW_HOLD: begin
          if (!flag && !hw_set) begin
            ph <= 2'd0;
            bitn <= 4'd0;
            if (code == `TW_SC_ARB) begin
              scl_oe <= 1'b0;
              sda_oe <= 1'b0;
              st <= start_request ? TW_WAIT : TW_IDLE;
            end else if (code == `TW_SC_SLV_W || code == `TW_SC_SLV_GC ||
                         code == `TW_SC_SLV_R) begin
              scl_oe <= 1'b0;
              st <= TW_IDLE;
            end else if (code == `TW_SC_START || code == `TW_SC_RSTART) begin
              // any slave after a repeated START
              // read bit selects master receive after the address
              is_addr <= 1'b1;
              rd_mode <= shift_data_reg[0];
              st <= TW_SEND;
            end else if (stop_request) begin
              st <= TW_STOP;
            end else if (start_request) begin
              // direction may change on the next address
              rep <= 1'b1;
              st <= TW_START;
            end else if (rd_mode) begin
              st <= TW_IDLE;
            end else begin
              is_addr <= 1'b0;
              st <= TW_SEND;
            end
          end
        end
        default: st <= TW_IDLE;
      endcase
    end
  end

endmodule
`default_nettype wire

// ### tw_master_tx_props.sv
// Purpose: port checks of the two-wire master transmitter
// Assumes: bound onto tw_master_tx
// Notes: flag state is learned from control reads
`timescale 1ns/1ps
`default_nettype none
`include "tw_consts.svh"
module tw_master_tx_props (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // wires
  input wire logic scl_in,
  input wire logic scl_out,
  input wire logic scl_oe,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe
);
  logic rd_ctl;
  logic flag_seen;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  always_ff @(posedge clk) begin
    rd_ctl <= reg_rd && reg_addr == `TW_A_CTL;
  end
  // set when a control read shows the flag, dropped by any control write
  always_ff @(posedge clk) begin
    if (rst || (reg_wr && reg_addr == `TW_A_CTL)) begin
      flag_seen <= 1'b0;
    end else if (rd_ctl && reg_rdata[`TW_B_FLAG]) begin
      flag_seen <= 1'b1;
    end
  end
  sequence s_own_wr; reg_wr && reg_addr == `TW_A_OWN; endsequence
  sequence s_own_rd; reg_rd && reg_addr == `TW_A_OWN; endsequence
  chk_rdata_quiet: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside read slot");
  chk_pins_low: assert property (!scl_out && !sda_out)
    else $error("open-drain level not low");
  chk_reset_free: assert property (disable iff (1'b0) rst |=> !scl_oe && !sda_oe)
    else $error("wires held during reset");
  chk_status_gap: assert property (reg_rd && reg_addr == `TW_A_STAT |=> !reg_rdata[2])
    else $error("status bit 2 not zero");
  chk_hold_wires: assert property (flag_seen && !reg_wr |=> $stable({scl_oe, sda_oe}))
    else $error("wires moved while flag set");
  chk_start_then_low: assert property ($rose(sda_oe) && !scl_oe && scl_in |-> ##[1:1000] scl_oe)
    else $error("clock not pulled low after start");
  chk_scl_high_min: assert property ($fell(scl_oe) |=> !scl_oe [*8])
    else $error("clock high time too short");
  chk_off_release: assert property (reg_wr && reg_addr == `TW_A_CTL && !reg_wdata[`TW_B_EN]
    |-> ##[1:16] (!scl_oe && !sda_oe))
    else $error("wires not released when disabled");
  chk_own_echo: assert property (s_own_wr ##2 s_own_rd |=> reg_rdata == $past(reg_wdata, 3))
    else $error("own address read back wrong");
endmodule
bind tw_master_tx tw_master_tx_props u_props (.clk(clk), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe(sda_oe));
`default_nettype wire

// ### tw_slave_model.sv
// Purpose: slave receiver on the two-wire bus
// Assumes: wires resolved with pull-ups by the bench
// Notes: acks its own address with write bit and the data after it
`timescale 1ns/1ps
`default_nettype none
module tw_slave_model #(
  parameter logic [6:0] ADDR = 7'h2a
) (
  // wires
  input wire logic scl,
  input wire logic sda,
  output logic ack_oe,
  // last byte taken while selected
  output logic [7:0] got
);
  logic [7:0] sh = 8'h00;
  int n = 0;
  logic sel = 1'b0;
  logic adr_ph = 1'b0;
  initial begin
    ack_oe = 1'b0;
    got = 8'h00;
  end
  // start: next byte is an address
  always @(negedge sda) begin
    if (scl) begin
      n = 0;
      adr_ph = 1'b1;
      sel = 1'b0;
    end
  end
  // stop: deselect
  always @(posedge sda) begin
    if (scl) begin
      n = 0;
      sel = 1'b0;
    end
  end
  // bits msb first on the rising clock
  always @(posedge scl) begin
    if (n < 8) begin
      sh = {sh[6:0], sda};
    end
    n = n + 1;
  end
  always @(negedge scl) begin
    if (n == 8) begin
      if (adr_ph) begin
        sel = (sh[7:1] == ADDR) && !sh[0];
      end else if (sel) begin
        got = sh;
      end
      ack_oe = sel;
      adr_ph = 1'b0;
    end else if (n == 9) begin
      ack_oe = 1'b0;
      n = 0;
    end
  end
endmodule
`default_nettype wire

// ### tw_tb.sv
// Purpose: self-checking bench of the two-wire master transmitter
// Assumes: one slave receiver at 7'h2a, pull-ups on both wires
// Notes: a byte takes about 18000 cycles, so the table is short
`timescale 1ns/1ps
`default_nettype none
`include "tw_consts.svh"
module testbench;
  typedef struct packed {
    logic ld;
    logic [7:0] d;
    logic [7:0] ctl;
    logic [7:0] code;
  } tw_row_t;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [1:0] reg_addr = 2'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic scl_oe;
  logic sda_oe;
  logic ack_oe;
  logic [7:0] slv_got;
  // a competing master that only pulls the data wire low
  logic other_oe = 1'b0;
  wire scl_w = ~scl_oe;
  wire sda_w = ~(sda_oe | ack_oe | other_oe);
  int err_total = 0;
  int checks_done = 0;
  tw_row_t rows [7] = '{
    '{1'b0, 8'h00, 8'ha4, `TW_SC_START},
    '{1'b1, 8'h54, 8'h84, `TW_SC_AW_ACK},
    '{1'b1, 8'h5a, 8'h84, `TW_SC_D_ACK},
    '{1'b0, 8'h00, 8'ha4, `TW_SC_RSTART},
    '{1'b1, 8'h2a, 8'h84, `TW_SC_AW_NACK},
    '{1'b1, 8'hc3, 8'h84, `TW_SC_D_NACK},
    '{1'b0, 8'h00, 8'hb4, `TW_SC_START}};
  always #2.5 clk = ~clk;
  tw_master_tx dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .scl_in(scl_w),
    .scl_out(), .scl_oe(scl_oe), .sda_in(sda_w), .sda_out(), .sda_oe(sda_oe));
  tw_slave_model #(.ADDR(7'h2a)) slv (.scl(scl_w), .sda(sda_w), .ack_oe(ack_oe),
    .got(slv_got));
  task automatic wrap_up;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] want);
    checks_done++;
    if (seen !== want) begin
      err_total++;
      $display("unexpected at %0t: seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  // polls the flag, bounded
  task automatic wait_flag;
    logic [7:0] c;
    int i;
    for (i = 0; i < 20000; i++) begin
      rd(`TW_A_CTL, c);
      if (c[`TW_B_FLAG] === 1'b1) break;
    end
    if (i == 20000) begin
      err_total++;
      wrap_up();
    end
  endtask
  task automatic reset_chk(input int n);
    logic [7:0] v;
    @(posedge clk);
    rst <= 1'b1;
    repeat (n) @(posedge clk);
    rst <= 1'b0;
    rd(`TW_A_STAT, v);
    chk(v, `TW_RST_CODE);
    rd(`TW_A_CTL, v);
    chk(v, 8'h00);
    rd(`TW_A_OWN, v);
    chk(v, `TW_RST_OWN);
  endtask
  initial begin
    logic [7:0] v;
    tw_row_t r;
    reset_chk(12);
    wr(`TW_A_DATA, 8'h77);
    rd(`TW_A_CTL, v);
    chk(v & 8'h08, 8'h08);
    foreach (rows[k]) begin
      r = rows[k];
      if (r.ld) begin
        wr(`TW_A_DATA, r.d);
      end
      wr(`TW_A_CTL, r.ctl);
      wait_flag();
      rd(`TW_A_STAT, v);
      chk(v & 8'hf8, r.code);
    end
    chk(slv_got, 8'h5a);
    rd(`TW_A_CTL, v);
    chk(v & 8'h10, 8'h00);
    wr(`TW_A_STAT, 8'h03);
    rd(`TW_A_STAT, v);
    chk(v, `TW_SC_START | 8'h03);
    wr(`TW_A_OWN, 8'h55);
    rd(`TW_A_OWN, v);
    chk(v, 8'h55);
    // arbitration lost in a data byte, then release and a START on a free bus
    wr(`TW_A_DATA, 8'h54);
    wr(`TW_A_CTL, 8'h84);
    wait_flag();
    rd(`TW_A_STAT, v);
    chk(v & 8'hf8, `TW_SC_AW_ACK);
    wr(`TW_A_DATA, 8'hff);
    other_oe <= 1'b1;
    wr(`TW_A_CTL, 8'h84);
    wait_flag();
    rd(`TW_A_STAT, v);
    chk(v & 8'hf8, `TW_SC_ARB);
    wr(`TW_A_CTL, 8'h84);
    repeat (20) @(posedge clk);
    chk({6'h00, scl_oe, sda_oe}, 8'h00);
    rd(`TW_A_CTL, v);
    chk(v & 8'h80, 8'h00);
    wr(`TW_A_CTL, 8'ha4);
    repeat (50) @(posedge clk);
    chk({6'h00, scl_oe, sda_oe}, 8'h00);
    other_oe <= 1'b0;
    wait_flag();
    rd(`TW_A_STAT, v);
    chk(v & 8'hf8, `TW_SC_START);
    wr(`TW_A_CTL, 8'h00);
    repeat (16) @(posedge clk);
    chk({6'h00, scl_oe, sda_oe}, 8'h00);
    reset_chk(3);
    wrap_up();
  end
endmodule
`default_nettype wire
